// [logic/sscr_regs.sv]
// Purpose: Status flags and system control registers over AXI4-Lite.
// Assumes: Core events and pins are synchronous to aclk.
// Notes: Summary of operation follows.
// Summary of operation
// - Status bits 7 and 6 read zero.
// - Timeout flag: set by timeout, cleared by watchdog clear or halt.
// - Power-down flag: halt sets, watchdog clear clears.
// - Status writes touch only four low flags.
// - Overflow is carry-in XOR carry-out of MSB.
// - Zero flag follows result equal to zero.
// - Half carry from low nibble carry.
// - Carry from carry out or rotate.
// - Direction bit one is input; bit ops.
// - Enabled port A falling edge wakes.
// - Pull-high only while pin is input.
// - Divider source: timer0 or timer1.
// - PWM format 6+2 or 7+1, ADC parts.
// - PWM pin select; prescaler from system clock.
// - Divider pin select routes divider output.
// - Slow crystal quick start or low power.
// - Clock mode picks slow crystal, stops RC, only with the RC-plus-slow-crystal option.
// - Edge field: off, rise, fall, both.
// - Time-base period two to ten..thirteen.
// - Watchdog off only for pattern 1010.
// - Option forces the watchdog always on.
module sscr_regs #(
    parameter int PA_W = 8,
    parameter int PB_W = 2,
    parameter bit ADC_VARIANT = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sscr_pkg::sscr_alu_type alu,
    input wire sscr_pkg::sscr_sys_type sys,
    input wire logic cfg_wdt_forced,
    input wire logic cfg_rc_plus_slow_xtal,
    input wire logic [PA_W-1:0] pa_pin,
    output logic [7:0] status_flags,
    output logic [PA_W-1:0] port_a_direction,
    output logic [PB_W-1:0] port_b_direction,
    output logic [PA_W-1:0] pa_pullup_en,
    output logic [PB_W-1:0] pb_pullup_en,
    output logic wake_req,
    output sscr_pkg::sscr_ctl_type ctl
);
    // =========================================
    // Constants and state
    // =========================================
    // Writable bits of control register zero for this variant.
    localparam logic [7:0] C0_MASK =
        ADC_VARIANT ? sscr_pkg::C0_ADC_MASK : sscr_pkg::C0_BASIC_MASK;
    // Registered state and its next value.
    sscr_pkg::sscr_state_type st_ff;
    sscr_pkg::sscr_state_type nxt_st;
    // Write strobe: address and data both held and no response pending.
    logic wr_fire;

    // Constant state after reset.
    function automatic sscr_pkg::sscr_state_type rst_state();
        sscr_pkg::sscr_state_type s;
        s = '0;
        s.system_control_zero_adc_variant = sscr_pkg::SYSCTL0_RST;
        s.system_control_one = sscr_pkg::SYSCTL1_RST;
        s.pa_dir = sscr_pkg::DIR_RST;
        s.pb_dir = sscr_pkg::DIR_RST;
        return s;
    endfunction : rst_state

    // True when an index names a register of the bank.
    function automatic logic mapped(input logic [5:0] i);
        return i == sscr_pkg::IDX_STATUS || i == sscr_pkg::IDX_PA_DIR ||
            i == sscr_pkg::IDX_PA_PULL || i == sscr_pkg::IDX_PA_WAKE ||
            i == sscr_pkg::IDX_PB_DIR || i == sscr_pkg::IDX_PB_PULL ||
            i == sscr_pkg::IDX_SYSCTL0 || i == sscr_pkg::IDX_SYSCTL1 ||
            i == sscr_pkg::IDX_DIRSET || i == sscr_pkg::IDX_DIRCLR;
    endfunction : mapped

    // Read value of one register; unused and set/clear aliases read zero.
    function automatic logic [7:0] rd_val(
        input sscr_pkg::sscr_state_type s,
        input logic [5:0] i
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            sscr_pkg::IDX_STATUS: v = {2'h0, s.status};
            sscr_pkg::IDX_PA_DIR: v = s.pa_dir;
            sscr_pkg::IDX_PA_PULL: v = s.pa_pu;
            sscr_pkg::IDX_PA_WAKE: v = s.pa_wk;
            sscr_pkg::IDX_PB_DIR: v = s.pb_dir;
            sscr_pkg::IDX_PB_PULL: v = s.pb_pu;
            sscr_pkg::IDX_SYSCTL0: v = s.system_control_zero_adc_variant;
            sscr_pkg::IDX_SYSCTL1: v = s.system_control_one;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : rd_val

    // Masks a register to the implemented pins of a port.
    function automatic logic [7:0] pin_mask(input int w);
        return 8'((16'h1 << w) - 16'h1);
    endfunction : pin_mask

    // Decodes the control registers into control outputs.
    function automatic sscr_pkg::sscr_ctl_type decode(
        input logic [7:0] c0,
        input logic [7:0] c1,
        input logic forced,
        input logic combo
    );
        sscr_pkg::sscr_ctl_type c;
        c = '0;
        c.div_src_t1 = c0[sscr_pkg::C0_DSRC];
        c.pwm_fmt_71 = c0[sscr_pkg::C0_PFMT];
        c.pwm_pin = c0[sscr_pkg::C0_PPIN];
        c.tp_from_sys = c0[sscr_pkg::C0_PPIN];
        c.div_pin = c0[sscr_pkg::C0_DPIN];
        c.slow_xtal_low_power = c0[sscr_pkg::C0_LXLP];
        c.clk_slow = c0[sscr_pkg::C0_CMOD] & combo;
        c.fast_rc_stop = c0[sscr_pkg::C0_CMOD] & combo;
        c.irq_rise = c1[sscr_pkg::C1_EDGE];
        c.irq_fall = c1[sscr_pkg::C1_EDGE+1];
        c.tb_exp = sscr_pkg::TB_EXP_BASE + {2'h0, c1[sscr_pkg::C1_TB +: 2]};
        c.wdt_en = forced ||
            (c1[sscr_pkg::C1_WDT +: 4] != sscr_pkg::WDT_OFF);
        return c;
    endfunction : decode

    // =========================================
    // Next-state logic
    // =========================================
    // Bus handshakes, register writes, flag updates and derived outputs.
    always_comb begin
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] m0;
        logic [7:0] m1;
        b0 = st_ff.wdata[7:0];
        b1 = st_ff.wdata[15:8];
        m0 = {8{st_ff.wstrb[0]}};
        m1 = {8{st_ff.wstrb[1]}};
        nxt_st = st_ff;
        wr_fire = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
        // Capture address and data independently, in either order.
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata = s_axi_wdata[15:0];
            nxt_st.wstrb = s_axi_wstrb[1:0];
        end
        // Response retires when the master accepts it.
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // Perform the write once both halves are held.
        if (wr_fire) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = mapped(st_ff.aw_idx) ?
                sscr_pkg::RESP_OKAY : sscr_pkg::RESP_SLVERR;
            unique case (st_ff.aw_idx)
                sscr_pkg::IDX_STATUS: begin
                    // Only the four arithmetic flags take bus data.
                    nxt_st.status[3:0] = (st_ff.status[3:0] & ~m0[3:0]) |
                        (b0[3:0] & m0[3:0] & sscr_pkg::STATUS_WR_MASK[3:0]);
                end
                sscr_pkg::IDX_PA_DIR: nxt_st.pa_dir = (st_ff.pa_dir & ~m0) | (b0 & m0);
                sscr_pkg::IDX_PB_DIR: nxt_st.pb_dir = (st_ff.pb_dir & ~m0) | (b0 & m0);
                sscr_pkg::IDX_DIRSET: begin
                    // Single-bit set: ones in the data set direction bits.
                    nxt_st.pa_dir = st_ff.pa_dir | (b0 & m0);
                    nxt_st.pb_dir = st_ff.pb_dir | (b1 & m1);
                end
                sscr_pkg::IDX_DIRCLR: begin
                    // Single-bit clear: ones in the data clear direction bits.
                    nxt_st.pa_dir = st_ff.pa_dir & ~(b0 & m0);
                    nxt_st.pb_dir = st_ff.pb_dir & ~(b1 & m1);
                end
                sscr_pkg::IDX_PA_PULL: nxt_st.pa_pu = (st_ff.pa_pu & ~m0) | (b0 & m0);
                sscr_pkg::IDX_PB_PULL: nxt_st.pb_pu = (st_ff.pb_pu & ~m0) | (b0 & m0);
                sscr_pkg::IDX_PA_WAKE: nxt_st.pa_wk = (st_ff.pa_wk & ~m0) | (b0 & m0);
                // Unimplemented positions stay zero.
                sscr_pkg::IDX_SYSCTL0: nxt_st.system_control_zero_adc_variant = (st_ff.system_control_zero_adc_variant & ~m0) | (b0 & m0 & C0_MASK);
                sscr_pkg::IDX_SYSCTL1: nxt_st.system_control_one = (st_ff.system_control_one & ~m0) | (b0 & m0);
                // Unmapped index: no state changes, error response.
                default: nxt_st.bresp = sscr_pkg::RESP_SLVERR;
            endcase
        end
        // Address and data channels stay closed until the response retires.
        nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;
        // Read channel: one read in flight, answered the next cycle.
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rd_idx = s_axi_araddr[7:2];
            nxt_st.rdata = rd_val(st_ff, s_axi_araddr[7:2]);
            nxt_st.rresp = mapped(s_axi_araddr[7:2]) ?
                sscr_pkg::RESP_OKAY : sscr_pkg::RESP_SLVERR;
        end
        nxt_st.arready = !nxt_st.rvalid;
        // ALU results override a same-cycle bus write of the flags.
        if (alu.arith) begin
            nxt_st.status[sscr_pkg::ST_OVF] = alu.carry_msb_in ^ alu.carry_out;
            nxt_st.status[sscr_pkg::ST_Z] = alu.result == 8'h00;
            nxt_st.status[sscr_pkg::ST_HC] = alu.nibble_carry;
            nxt_st.status[sscr_pkg::ST_C] = alu.carry_out;
        end else if (alu.logic_op) begin
            nxt_st.status[sscr_pkg::ST_Z] = alu.result == 8'h00;
        end else if (alu.rotate) begin
            nxt_st.status[sscr_pkg::ST_C] = alu.rot_carry;
        end
        // Timeout flag: a time-out in the same cycle beats the clear.
        if (sys.wdt_timeout) begin
            nxt_st.status[sscr_pkg::ST_TMO] = 1'b1;
        end else if (sys.watchdog_clear_instruction || sys.halt) begin
            nxt_st.status[sscr_pkg::ST_TMO] = 1'b0;
        end
        // Power-down flag: halt sets it, watchdog clear clears it.
        if (sys.halt) begin
            nxt_st.status[sscr_pkg::ST_PWRDN] = 1'b1;
        end else if (sys.watchdog_clear_instruction) begin
            nxt_st.status[sscr_pkg::ST_PWRDN] = 1'b0;
        end
        // Pull-high is gated by the input direction of each pin.
        nxt_st.pa_pull = st_ff.pa_pu & st_ff.pa_dir & pin_mask(PA_W);
        nxt_st.pb_pull = st_ff.pb_pu & st_ff.pb_dir & pin_mask(PB_W);
        // Falling edge on an enabled port A pin requests wake-up.
        nxt_st.pa_prev = 8'(pa_pin);
        nxt_st.wake = |(st_ff.pa_prev & ~8'(pa_pin) & st_ff.pa_wk & pin_mask(PA_W));
        nxt_st.ctl = decode(st_ff.system_control_zero_adc_variant, st_ff.system_control_one, cfg_wdt_forced, cfg_rc_plus_slow_xtal);
    end

    // =========================================
    // State register
    // =========================================
    // Synchronous active-low reset to constant values.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= rst_state();
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =========================================
    // Outputs, all straight from the state register
    // =========================================
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rdata = {24'h000000, st_ff.rdata};
    assign status_flags = {2'h0, st_ff.status};
    assign port_a_direction = st_ff.pa_dir[PA_W-1:0];
    assign port_b_direction = st_ff.pb_dir[PB_W-1:0];
    assign pa_pullup_en = st_ff.pa_pull[PA_W-1:0];
    assign pb_pullup_en = st_ff.pb_pull[PB_W-1:0];
    assign wake_req = st_ff.wake;
    assign ctl = st_ff.ctl;

    // =========================================
    // Assertions
    // =========================================
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // A status read answers with both top bits zero.
    chk_status_top_zero: assert property (
        st_ff.rvalid && st_ff.rd_idx == sscr_pkg::IDX_STATUS |-> st_ff.rdata[7:6] == 2'h0)
        else $error("status top bits read nonzero");

    // A time-out sets the flag on the next edge, even with a clear.
    chk_timeout_set: assert property (
        sys.wdt_timeout |=> st_ff.status[sscr_pkg::ST_TMO])
        else $error("timeout flag not set");

    // Clear or halt without a time-out clears the flag.
    chk_timeout_clear: assert property (
        (sys.watchdog_clear_instruction || sys.halt) && !sys.wdt_timeout |=> !st_ff.status[sscr_pkg::ST_TMO])
        else $error("timeout flag not cleared");

    // Halt sets power-down; a lone watchdog clear clears it.
    chk_pdf_track: assert property (
        sys.halt || sys.watchdog_clear_instruction |=> st_ff.status[sscr_pkg::ST_PWRDN] == $past(sys.halt))
        else $error("power-down flag wrong");

    // Flag writes never disturb the two system flags.
    sequence s_status_write;
        wr_fire && st_ff.aw_idx == sscr_pkg::IDX_STATUS && sys == '0;
    endsequence
    chk_sysflag_guard: assert property (
        s_status_write |=> $stable(st_ff.status[5:4]))
        else $error("status write changed system flags");

    // Overflow, half carry and carry follow the arithmetic result.
    chk_arith_flags: assert property (
        alu.arith |=> st_ff.status[3] == $past(alu.carry_msb_in ^ alu.carry_out) &&
            st_ff.status[1] == $past(alu.nibble_carry) && st_ff.status[0] == $past(alu.carry_out))
        else $error("arithmetic flags wrong");

    // Zero flag tracks a zero result of arithmetic or logic.
    chk_zero_flag: assert property (
        alu.arith || alu.logic_op |=> st_ff.status[sscr_pkg::ST_Z] == ($past(alu.result) == 8'h00))
        else $error("zero flag wrong");

    // Rotate through carry loads the carry alone.
    chk_rotate_carry: assert property (
        alu.rotate && !alu.arith && !alu.logic_op |=> st_ff.status[0] == $past(alu.rot_carry))
        else $error("rotate carry wrong");

    // Pull-high output equals select and input direction.
    chk_pullup_gate: assert property (
        ##1 pa_pullup_en == $past(st_ff.pa_pu[PA_W-1:0] & st_ff.pa_dir[PA_W-1:0]))
        else $error("pull-high not gated by direction");

    // An enabled falling edge raises wake two edges after the high level.
    sequence s_fall_enabled;
        (|(8'(pa_pin) & st_ff.pa_wk)) ##1 (|(st_ff.pa_prev & ~8'(pa_pin) & st_ff.pa_wk));
    endsequence
    chk_wake_edge: assert property (
        s_fall_enabled |=> wake_req)
        else $error("falling edge did not wake");

    // Watchdog off only when not forced and the field holds the off pattern.
    chk_wdt_enable: assert property (
        ##1 ctl.wdt_en == $past(cfg_wdt_forced || st_ff.system_control_one[3:0] != 4'hA))
        else $error("watchdog enable wrong");

    // Unimplemented bits of control register zero stay zero.
    chk_system_control_zero_adc_variant_unimpl: assert property (
        (st_ff.system_control_zero_adc_variant & ~C0_MASK) == 8'h00)
        else $error("unimplemented control bit set");

    // Both write halves held give a response on the next edge.
    chk_write_resp: assert property (
        wr_fire |=> st_ff.bvalid ##0 !st_ff.awready)
        else $error("write response missing");
endmodule : sscr_regs

// [logic/sscr_pkg.sv]
// Purpose: Shared constants and types of the system status/control bank.
// Assumes: Registers are 8 bits in the low byte of an aligned 32-bit word.
// Notes: Byte address is four times the register index.
package sscr_pkg;
    // =========================================
    // Register indices
    // =========================================
    localparam logic [5:0] IDX_STATUS = 6'h0A;
    localparam logic [5:0] IDX_PA_DIR = 6'h11;
    localparam logic [5:0] IDX_PA_PULL = 6'h12;
    localparam logic [5:0] IDX_PA_WAKE = 6'h13;
    localparam logic [5:0] IDX_PB_DIR = 6'h15;
    localparam logic [5:0] IDX_PB_PULL = 6'h16;
    localparam logic [5:0] IDX_SYSCTL0 = 6'h1A;
    localparam logic [5:0] IDX_SYSCTL1 = 6'h1B;
    localparam logic [5:0] IDX_DIRSET = 6'h38;
    localparam logic [5:0] IDX_DIRCLR = 6'h39;
    // =========================================
    // Field positions
    // =========================================
    localparam int ST_TMO = 5;
    localparam int ST_PWRDN = 4;
    localparam int ST_OVF = 3;
    localparam int ST_Z = 2;
    localparam int ST_HC = 1;
    localparam int ST_C = 0;
    localparam int C0_DSRC = 6;
    localparam int C0_PFMT = 5;
    localparam int C0_PPIN = 3;
    localparam int C0_DPIN = 2;
    localparam int C0_LXLP = 1;
    localparam int C0_CMOD = 0;
    localparam int C1_EDGE = 6;
    localparam int C1_TB = 4;
    localparam int C1_WDT = 0;
    // =========================================
    // Masks and reset values
    // =========================================
    localparam logic [7:0] STATUS_WR_MASK = 8'h0F;
    localparam logic [7:0] C0_ADC_MASK = 8'h6F;
    localparam logic [7:0] C0_BASIC_MASK = 8'h47;
    localparam logic [7:0] SYSCTL0_RST = 8'h00;
    localparam logic [7:0] SYSCTL1_RST = 8'h8A;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [3:0] WDT_OFF = 4'hA;
    localparam logic [3:0] TB_EXP_BASE = 4'hA;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // =========================================
    // Carriers
    // =========================================
    // One ALU result with its carry information.
    typedef struct packed {
        logic arith;
        logic logic_op;
        logic rotate;
        logic [7:0] result;
        logic carry_out;
        logic carry_msb_in;
        logic nibble_carry;
        logic rot_carry;
    } sscr_alu_type;
    // Core system events, one-cycle pulses.
    typedef struct packed {
        logic wdt_timeout;
        logic watchdog_clear_instruction;
        logic halt;
    } sscr_sys_type;
    // Decoded control outputs.
    typedef struct packed {
        logic div_src_t1;
        logic pwm_fmt_71;
        logic pwm_pin;
        logic div_pin;
        logic slow_xtal_low_power;
        logic clk_slow;
        logic fast_rc_stop;
        logic tp_from_sys;
        logic irq_rise;
        logic irq_fall;
        logic [3:0] tb_exp;
        logic wdt_en;
    } sscr_ctl_type;
    // Whole state of the bank.
    typedef struct packed {
        logic [5:0] status;
        logic [7:0] system_control_zero_adc_variant;
        logic [7:0] system_control_one;
        logic [7:0] pa_dir;
        logic [7:0] pb_dir;
        logic [7:0] pa_pu;
        logic [7:0] pb_pu;
        logic [7:0] pa_wk;
        logic [7:0] pa_prev;
        logic [7:0] pa_pull;
        logic [7:0] pb_pull;
        logic wake;
        sscr_ctl_type ctl;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [5:0] aw_idx;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [5:0] rd_idx;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } sscr_state_type;
endpackage : sscr_pkg

// [dv/sscr_regs_test.sv]
// Purpose: Self-checking bench of the status and control register bank.
// Assumes: Index constants of sscr_pkg; byte address is four times the index.
// Notes: Bus tasks wait on handshakes; a cycle ceiling cuts a hang short.
module sscr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================
    // Signals
    // =========================================
    logic aclk, aresetn, awv, wv, brdy, arv, rrdy, awr, wr_r, bv, arr, rv, cf, cc, wk;
    logic [7:0] awa, ara, st, pad, pull_a, pin;
    logic [31:0] wd, rdat, got;
    logic [3:0] ws;
    logic [1:0] br, rr, pbd, pull_b, resp;
    sscr_pkg::sscr_alu_type alu;
    sscr_pkg::sscr_sys_type sys;
    sscr_pkg::sscr_ctl_type ctl;
    int errors, n_checks, cyc;
    sscr_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .alu(alu), .sys(sys), .cfg_wdt_forced(cf), .cfg_rc_plus_slow_xtal(cc), .pa_pin(pin), .status_flags(st),
        .port_a_direction(pad), .port_b_direction(pbd), .pa_pullup_en(pull_a), .pb_pullup_en(pull_b),
        .wake_req(wk), .ctl(ctl));
    // The clock toggles every half period of 5 ns.
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // =========================================
    // Shared tasks
    // =========================================
    // Counts one comparison and reports a mismatch.
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One AXI write; address and data are released as each is taken.
    task automatic wr(input logic [5:0] i, input logic [15:0] d);
        awa <= {i, 2'h0};
        wd <= {16'h0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv);
        resp = br;
        brdy <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : wr
    // One AXI read; data and response are taken at the rvalid edge.
    task automatic rd(input logic [5:0] i);
        ara <= {i, 2'h0};
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        got = rdat;
        resp = rr;
        rrdy <= 1'b0;
        @(posedge aclk);
    endtask : rd
    // Pulses one ALU and system event, then lets the flags settle.
    task automatic ev(input logic [14:0] a, input logic [2:0] s);
        alu <= a;
        sys <= s;
        @(posedge aclk);
        alu <= '0;
        sys <= '0;
        repeat (2) @(posedge aclk);
    endtask : ev
    // Drives the pins and records any wake pulse in the next cycles.
    task automatic watch(input logic [7:0] p, output logic w);
        pin <= p;
        w = 1'b0;
        repeat (4) begin
            @(posedge aclk);
            w = w | wk;
        end
    endtask : watch
    // =========================================
    // Scenarios
    // =========================================
    // Reset values read back over the bus and seen on the outputs.
    task automatic t_reset;
        rd(sscr_pkg::IDX_STATUS);
        chk("status rst", got, 32'h00000000);
        rd(sscr_pkg::IDX_SYSCTL1);
        chk("sysctl1 rst", got, {24'h000000, sscr_pkg::SYSCTL1_RST});
        chk("dir rst", pad, 8'hFF);
        chk("ctl rst", {ctl.irq_fall, ctl.tb_exp, ctl.wdt_en}, 6'h34);
        $display("reset test done");
    endtask : t_reset
    task automatic t_status;
        wr(sscr_pkg::IDX_STATUS, 16'h00FF);
        rd(sscr_pkg::IDX_STATUS);
        chk("status wr", got, 32'h0000000F);
        ev(15'h0000, 3'b001);
        chk("halt", st, 8'h1F);
        ev(15'h0000, 3'b100);
        chk("timeout", st, 8'h3F);
        ev(15'h0000, 3'b001);
        chk("halt clears timeout", st, 8'h1F);
        ev(15'h0000, 3'b110);
        chk("timeout beats clear", st, 8'h2F);
        wr(sscr_pkg::IDX_STATUS, 16'h0000);
        chk("keep sys flags", st, 8'h20);
        chk("write okay", resp, 2'h0);
        ev(15'h0000, 3'b010);
        chk("wdt clear", st, 8'h00);
        ev({3'b100, 8'h80, 4'b0100}, 3'b000);
        chk("overflow in", st, 8'h08);
        ev({3'b100, 8'h00, 4'b1010}, 3'b000);
        chk("overflow out", st, 8'h0F);
        ev({3'b100, 8'h00, 4'b1100}, 3'b000);
        chk("no overflow", st, 8'h05);
        ev({3'b010, 8'h5A, 4'b0000}, 3'b000);
        chk("logic z", st[2], 1'b0);
        ev({3'b001, 8'h5A, 4'b1000}, 3'b000);
        chk("rotate c", st[0], 1'b0);
        $display("status test done");
    endtask : t_status
    task automatic t_ctrl;
        cc <= 1'b1;
        wr(sscr_pkg::IDX_SYSCTL0, 16'h00FF);
        rd(sscr_pkg::IDX_SYSCTL0);
        chk("sysctl0", got, 32'h0000006F);
        chk("ctl on", ctl[14:7], 8'hFF);
        cc <= 1'b0;
        wr(sscr_pkg::IDX_SYSCTL0, 16'h0001);
        chk("ctl mode", ctl[14:7], 8'h00);
        for (int k = 0; k < 4; k++) begin
            cf <= k[1];
            wr(sscr_pkg::IDX_SYSCTL1, {8'h00, k[1:0], k[1:0], k[0] ? 4'h5 : 4'hA});
            chk("edge", {ctl.irq_rise, ctl.irq_fall}, {k[0], k[1]});
            chk("tb", ctl.tb_exp, 4'hA + k[3:0]);
            chk("wdt", ctl.wdt_en, k[0] | k[1]);
        end
        $display("control test done");
    endtask : t_ctrl
    task automatic t_ports;
        logic w;
        wr(sscr_pkg::IDX_PA_DIR, 16'h000F);
        wr(sscr_pkg::IDX_PA_PULL, 16'h003C);
        chk("pull", pull_a, 8'h0C);
        wr(sscr_pkg::IDX_DIRCLR, 16'h0301);
        wr(sscr_pkg::IDX_DIRSET, 16'h0280);
        chk("dirs", {pbd, pad}, 10'h28E);
        wr(sscr_pkg::IDX_PB_PULL, 16'h0003);
        chk("pull b", pull_b, 2'h2);
        wr(sscr_pkg::IDX_PA_WAKE, 16'h0001);
        watch(8'hFD, w);
        chk("no wake", w, 1'b0);
        watch(8'hFC, w);
        chk("wake", w, 1'b1);
        rd(6'h3F);
        chk("unmapped rd resp", resp, 2'h2);
        chk("unmapped rd data", got, 32'h00000000);
        wr(6'h3F, 16'h00FF);
        chk("unmapped wr resp", resp, 2'h2);
        $display("port test done");
    endtask : t_ports
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    // A hang counts as a mismatch and closes the run.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        {aresetn, awv, wv, brdy, arv, rrdy, cf, cc, awa, ara, wd, alu, sys, cyc} = '0;
        ws = 4'hF;
        pin = 8'hFF;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_status();
        t_ctrl();
        t_ports();
        finish_test();
    end
endmodule : sscr_regs_test
